/* rtl/cur_adc_post.sv */
// current-channel result counter and digital comparator with register port
//
// Functional notes
// RL1 - read-only 16-bit conversion count increments while result counter is enabled
// RL2 - count equal to limit clears to zero and counting continues
// RL3 - with counter on, conversion interrupt only when the count hits its limit
// RL4 - counting happens only while configuration bit zero is set
// RL5 - writing channel control or mode register clears the conversion count
// RL6 - result magnitude compared against a software 16-bit threshold
// RL7 - unipolar compares sixteen threshold bits, two's complement only low fifteen
// RL8 - magnitude at or above threshold increments the 8-bit read-only counter
// RL9 - magnitude below threshold decrements or clears that counter, as configured
// RL10 - counter equal to count limit sets threshold flag and raises interrupt
// RL11 - configuration bits enable comparator and pick decrement or clear
// RL12 - 8-bit read/write threshold count limit resets to one
// RL13 - counter never goes below zero; both counters update once per result
`timescale 1ns/1ps
`default_nettype none
`include "cur_adc_post_map.svh"

module cur_adc_post
    import cur_adc_post_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int THV_W = 8
)
(
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // register port
    input  wire logic [31:0] ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // conversion stream
    input  wire logic        CONV_VALID_I,
    input  wire logic [15:0] CONV_DATA_I,
    // interrupt
    output logic             IRQ_O
);

    reg_req_t     req;
    conv_result_t conv;
    adc_config_t  cfg_r;

    logic [CNT_W-1:0] rc_limit_r;
    logic [CNT_W-1:0] rc_value_r;
    logic [CNT_W-1:0] rc_value_nxt;
    logic [15:0]      threshold_r;
    logic [THV_W-1:0] tc_limit_r;
    logic [THV_W-1:0] tc_value_r;
    logic [THV_W-1:0] tc_value_nxt;
    logic [15:0]      chan_ctrl_r;
    logic [15:0]      mode_r;
    logic [1:0]       status_r;
    logic [1:0]       irq_en_r;
    logic [1:0]       status_set;
    logic [1:0]       status_clr;
    logic             twos;
    logic             above;
    logic             reconfig;
    logic [31:0]      rdata_nxt;

    assign req  = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign conv = '{valid: CONV_VALID_I, data: CONV_DATA_I};
    assign twos = chan_ctrl_r[`CTRL_TWOS_COMPLEMENT];

    function automatic logic wr_hit(input reg_req_t r, input logic [31:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction

    // magnitude of a result and the compare against the threshold
    function automatic logic at_or_above(input logic [15:0] d, input logic [15:0] th,
                                         input logic tc);
        logic [15:0] mag;
        mag = 16'h0000;
        if (tc)
        begin
            mag = d[15] ? (~d + 16'h0001) : d;
            at_or_above = ({1'b0, mag[14:0]} >= {1'b0, th[14:0]}) || (mag == 16'h8000);
        end
        else
        begin
            at_or_above = d >= th;
        end
    endfunction

    assign above    = at_or_above(conv.data, threshold_r, twos); // RL6 RL7
    assign reconfig = wr_hit(req, `OFS_CURRENT_CHANNEL_CTRL)
                   || wr_hit(req, `OFS_ADC_MODE_REGISTER);

    // result counter next value
    always_comb
    begin
        rc_value_nxt = rc_value_r;
        if (reconfig)
            rc_value_nxt = '0; // RL5
        else if (conv.valid && cfg_r.result_cnt_en) // RL4 RL13
        begin
            if (rc_value_r + 1'b1 == rc_limit_r)
                rc_value_nxt = '0; // RL2
            else
                rc_value_nxt = rc_value_r + 1'b1; // RL1
        end
    end

    // above-threshold counter next value
    always_comb
    begin
        tc_value_nxt = tc_value_r;
        if (conv.valid && cfg_r.comp_en) // RL11 RL13
        begin
            if (above)
            begin
                if (tc_value_r != {THV_W{1'b1}})
                    tc_value_nxt = tc_value_r + 1'b1; // RL8
            end
            else if (cfg_r.clear_below)
                tc_value_nxt = '0; // RL9
            else if (tc_value_r != '0)
                tc_value_nxt = tc_value_r - 1'b1; // RL9 RL13
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rc_value_r <= `RST_ZERO16;
        else
            rc_value_r <= rc_value_nxt;
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            tc_value_r <= `RST_ZERO8;
        else
            tc_value_r <= tc_value_nxt;
    end

    // software-written registers
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rc_limit_r  <= `RST_RESULT_COUNT_LIMIT;
            threshold_r <= `RST_ZERO16;
            tc_limit_r  <= `RST_THRESHOLD_COUNT_LIMIT; // RL12
            cfg_r       <= '0;
            chan_ctrl_r <= `RST_ZERO16;
            mode_r      <= `RST_ZERO16;
            irq_en_r    <= '0;
        end
        else
        begin
            if (wr_hit(req, `OFS_RESULT_COUNT_LIMIT))
                rc_limit_r <= req.wdata[CNT_W-1:0];
            if (wr_hit(req, `OFS_CURRENT_THRESHOLD))
                threshold_r <= req.wdata[15:0]; // RL6
            if (wr_hit(req, `OFS_THRESHOLD_COUNT_LIMIT))
                tc_limit_r <= req.wdata[THV_W-1:0]; // RL12
            if (wr_hit(req, `OFS_ADC_CONFIGURATION))
                cfg_r <= '{clear_below: req.wdata[`CFG_COMP_CLEAR_BELOW],
                           comp_en: req.wdata[`CFG_COMP_EN],
                           result_cnt_en: req.wdata[`CFG_RESULT_CNT_EN]}; // RL11
            if (wr_hit(req, `OFS_CURRENT_CHANNEL_CTRL))
                chan_ctrl_r <= req.wdata[15:0];
            if (wr_hit(req, `OFS_ADC_MODE_REGISTER))
                mode_r <= req.wdata[15:0];
            if (wr_hit(req, `OFS_IRQ_ENABLE))
                irq_en_r <= req.wdata[1:0];
        end
    end

    // sticky status: conversion event gated by the result counter, threshold flag
    always_comb
    begin
        status_set = 2'b00;
        if (conv.valid)
            status_set[`STA_CONV_READY] = !cfg_r.result_cnt_en
                                       || (rc_value_nxt == '0 && !reconfig); // RL3
        status_set[`STA_THRESHOLD] = conv.valid && cfg_r.comp_en
                                  && (tc_value_nxt == tc_limit_r); // RL10
        status_clr = wr_hit(req, `OFS_IRQ_CLEAR) ? req.wdata[1:0] : 2'b00;
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            status_r <= '0;
        else
            status_r <= (status_r & ~status_clr) | status_set;
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= |((((status_r & ~status_clr) | status_set)) & irq_en_r); // RL3 RL10
    end

    // read decode
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (req.addr)
            `OFS_RESULT_COUNT_LIMIT:    rdata_nxt[CNT_W-1:0] = rc_limit_r;
            `OFS_RESULT_COUNT_VALUE:    rdata_nxt[CNT_W-1:0] = rc_value_r; // RL1
            `OFS_CURRENT_THRESHOLD:     rdata_nxt[15:0]      = threshold_r;
            `OFS_THRESHOLD_COUNT_LIMIT: rdata_nxt[THV_W-1:0] = tc_limit_r;
            `OFS_THRESHOLD_COUNT_VALUE: rdata_nxt[THV_W-1:0] = tc_value_r; // RL8
            `OFS_ADC_CONFIGURATION:     rdata_nxt[2:0]       = cfg_r;
            `OFS_CURRENT_CHANNEL_CTRL:  rdata_nxt[15:0]      = chan_ctrl_r;
            `OFS_ADC_MODE_REGISTER:     rdata_nxt[15:0]      = mode_r;
            `OFS_ADC_STATUS_FLAGS:      rdata_nxt[1:0]       = status_r;
            `OFS_IRQ_ENABLE:            rdata_nxt[1:0]       = irq_en_r;
            default:                    rdata_nxt            = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 32'h0000_0000;
        else if (req.rd)
            RDATA_O <= rdata_nxt;
        else
            RDATA_O <= 32'h0000_0000;
    end

    sequence s_cfg_wr;
        wr_hit(req, `OFS_CURRENT_CHANNEL_CTRL) || wr_hit(req, `OFS_ADC_MODE_REGISTER);
    endsequence

    sequence s_zero_count;
        rc_value_r == '0;
    endsequence

    a_reconfig_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL5
        s_cfg_wr |=> s_zero_count)
        else $error("count not cleared by reconfiguration");

    a_count_wraps: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL2
        (conv.valid && cfg_r.result_cnt_en && !reconfig && rc_value_r + 1'b1 == rc_limit_r)
        |=> rc_value_r == '0)
        else $error("result count did not wrap at limit");

    a_count_steps: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL1
        (conv.valid && cfg_r.result_cnt_en && !reconfig && rc_value_r + 1'b1 != rc_limit_r)
        |=> rc_value_r == $past(rc_value_r) + 1'b1)
        else $error("result count did not increment");

    a_count_holds: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL4
        (!cfg_r.result_cnt_en && !reconfig) |=> $stable(rc_value_r))
        else $error("result count moved while disabled");

    a_above_incr: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL8
        (conv.valid && cfg_r.comp_en && above && tc_value_r != 8'hff)
        |=> tc_value_r == $past(tc_value_r) + 1'b1)
        else $error("threshold count did not increment");

    a_below_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL9
        (conv.valid && cfg_r.comp_en && !above && cfg_r.clear_below) |=> tc_value_r == '0)
        else $error("threshold count not cleared below threshold");

    a_below_floor: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL13
        (conv.valid && cfg_r.comp_en && !above && !cfg_r.clear_below)
        |=> tc_value_r == (($past(tc_value_r) == '0) ? '0 : $past(tc_value_r) - 1'b1))
        else $error("threshold count decrement wrong");

    a_flag_on_limit: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL10
        (conv.valid && cfg_r.comp_en && tc_value_nxt == tc_limit_r)
        |=> status_r[`STA_THRESHOLD] ##1 (IRQ_O || !$past(irq_en_r[`STA_THRESHOLD])
                                          || $past(status_clr[`STA_THRESHOLD])))
        else $error("threshold flag or interrupt missing");

    a_masked_conv: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL3
        (!status_r[`STA_CONV_READY] && cfg_r.result_cnt_en && conv.valid && rc_value_nxt != '0)
        |=> !status_r[`STA_CONV_READY])
        else $error("conversion event not suppressed by result counter");

    a_limit_reset: assert property (@(posedge CLK_SYS_I) // RL12
        $rose(RST_N_I) |-> tc_limit_r == 8'h01)
        else $error("threshold count limit reset value wrong");

    sequence s_wrap_step;
        conv.valid && cfg_r.result_cnt_en && !reconfig && rc_value_r + 1'b1 == rc_limit_r;
    endsequence

    a_wrap_event: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL3
        s_wrap_step |=> status_r[`STA_CONV_READY])
        else $error("no conversion event at result count limit");

    a_free_conv_event: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL3
        (conv.valid && !cfg_r.result_cnt_en) |=> status_r[`STA_CONV_READY])
        else $error("conversion event missing with result counter off");

    a_reconfig_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL5
        (reconfig && conv.valid && cfg_r.result_cnt_en && !status_r[`STA_CONV_READY])
        |=> !status_r[`STA_CONV_READY])
        else $error("conversion event raised during reconfiguration");

    a_count_read_only: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL1
        (wr_hit(req, `OFS_RESULT_COUNT_VALUE) && !conv.valid) |=> $stable(rc_value_r))
        else $error("result count changed by a software write");

    a_count_readback: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL1
        (req.rd && req.addr == `OFS_RESULT_COUNT_VALUE)
        |=> RDATA_O[CNT_W-1:0] == $past(rc_value_r))
        else $error("result count read back wrong");

    a_rdata_idle: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL1
        !req.rd |=> RDATA_O == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_cmp_count_holds: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL11
        !(conv.valid && cfg_r.comp_en) |=> $stable(tc_value_r))
        else $error("threshold count moved without a compared result");

    a_cmp_count_saturates: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL8
        (conv.valid && cfg_r.comp_en && above && tc_value_r == {THV_W{1'b1}})
        |=> tc_value_r == {THV_W{1'b1}})
        else $error("threshold count wrapped past its maximum");

    a_status_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL10
        (status_r != 2'b00 && status_clr == 2'b00)
        |=> (status_r & $past(status_r)) == $past(status_r))
        else $error("status bit dropped without a clear");

    a_set_beats_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL10
        (conv.valid && cfg_r.comp_en && tc_value_nxt == tc_limit_r
         && status_clr[`STA_THRESHOLD])
        |=> status_r[`STA_THRESHOLD])
        else $error("threshold flag lost to a same-cycle clear");

    a_irq_high: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL10
        ((status_r & irq_en_r) != 2'b00 && status_clr == 2'b00) |=> IRQ_O)
        else $error("interrupt low while an enabled status bit is set");

    a_irq_low: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL3
        ((status_r & irq_en_r) == 2'b00 && status_set == 2'b00) |=> !IRQ_O)
        else $error("interrupt high with no enabled status bit");

    a_rc_limit_reset: assert property (@(posedge CLK_SYS_I) // RL2
        $rose(RST_N_I) |-> rc_limit_r == `RST_RESULT_COUNT_LIMIT)
        else $error("result count limit reset value wrong");

endmodule
`default_nettype wire

/* rtl/cur_adc_post_map.svh */
// register offsets, reset values and field positions for the current-channel post-processor
`ifndef CUR_ADC_POST_MAP_SVH
`define CUR_ADC_POST_MAP_SVH
`define OFS_RESULT_COUNT_LIMIT    32'hffff0548
`define OFS_RESULT_COUNT_VALUE    32'hffff054c
`define OFS_CURRENT_THRESHOLD     32'hffff0550
`define OFS_THRESHOLD_COUNT_LIMIT 32'hffff0554
`define OFS_THRESHOLD_COUNT_VALUE 32'hffff0558
`define OFS_ADC_CONFIGURATION     32'hffff0560
`define OFS_CURRENT_CHANNEL_CTRL  32'hffff0564
`define OFS_ADC_MODE_REGISTER     32'hffff0568
`define OFS_ADC_STATUS_FLAGS      32'hffff056c
`define OFS_IRQ_ENABLE            32'hffff0570
`define OFS_IRQ_CLEAR             32'hffff0574
`define RST_RESULT_COUNT_LIMIT    16'h0001
`define RST_THRESHOLD_COUNT_LIMIT 8'h01
`define RST_ZERO16                16'h0000
`define RST_ZERO8                 8'h00
`define RST_ZERO4                 4'h0
`define CFG_RESULT_CNT_EN         0
`define CFG_COMP_EN               1
`define CFG_COMP_CLEAR_BELOW      2
`define CTRL_TWOS_COMPLEMENT      0
`define STA_CONV_READY            0
`define STA_THRESHOLD             1
`endif

/* rtl/cur_adc_post_pkg.sv */
// types for the current-channel post-processor
package cur_adc_post_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } conv_result_t;

    typedef struct packed {
        logic clear_below;
        logic comp_en;
        logic result_cnt_en;
    } adc_config_t;
endpackage

/* bench/conv_source.sv */
// conversion result source model for the current-channel post-processor
`timescale 1ns/1ps
`default_nettype none

module conv_source
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // command from bench
    input  wire logic        send_i,
    input  wire logic [15:0] value_i,
    // result stream
    output logic             valid_o,
    output logic      [15:0] data_o
);
    // one-cycle result pulse, data scrambled outside valid cycles
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            valid_o <= 1'b0;
            data_o  <= 16'h5a5a;
        end
        else
        begin
            valid_o <= send_i;
            data_o  <= send_i ? value_i : ~data_o;
        end
    end
endmodule

`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the current-channel post-processor
`timescale 1ns/1ps
`default_nettype none
`include "cur_adc_post_map.svh"

module testbench;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] addr  = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        send  = 1'b0;
    logic [15:0] value = 16'h0;
    logic [31:0] rdata;
    logic        cvalid;
    logic [15:0] cdata;
    logic        irq;
    int          bad_count = 0;
    int          n_tests   = 0;
    logic [31:0] d;
    logic [15:0] th;
    logic [15:0] v;
    logic [7:0]  tcl;
    logic [7:0]  thv;
    logic        tc;
    logic        clr;
    logic        flag;

    always #5 clk = ~clk;

    cur_adc_post u_cur_adc_post (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CONV_VALID_I(cvalid),
        .CONV_DATA_I(cdata), .IRQ_O(irq));
    conv_source u_conv_source (.clk_i(clk), .rst_n_i(rst_n), .send_i(send), .value_i(value),
        .valid_o(cvalid), .data_o(cdata));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] x);
        @(posedge clk);
        addr  <= a;
        wdata <= x;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [31:0] a, output logic [31:0] x);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        x = rdata;
    endtask

    task automatic chk_reg(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] x;
        rd_reg(a, x);
        check(name, x, exp);
    endtask

    task automatic conv(input logic [15:0] x);
        @(posedge clk);
        send  <= 1'b1;
        value <= x;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // magnitude at or above threshold, sign handling per coding
    function automatic logic is_above(input logic [15:0] x, input logic [15:0] t, input logic c);
        logic [15:0] m;
        m = x[15] ? (~x + 16'h1) : x;
        if (!c)
            return x >= t;
        return (m == 16'h8000) || (m[14:0] >= t[14:0]);
    endfunction

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'hdb5a58bd));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg("rcl_rst", `OFS_RESULT_COUNT_LIMIT, 32'h1);
        check("irq_rst", {31'h0, irq}, 32'h0);
        chk_reg("rcv_rst", `OFS_RESULT_COUNT_VALUE, 32'h0);
        chk_reg("th_rst", `OFS_CURRENT_THRESHOLD, 32'h0);
        chk_reg("tcl_rst", `OFS_THRESHOLD_COUNT_LIMIT, 32'h1);
        chk_reg("thv_rst", `OFS_THRESHOLD_COUNT_VALUE, 32'h0);
        wr_reg(`OFS_RESULT_COUNT_VALUE, 32'hffff);
        chk_reg("rcv_ro", `OFS_RESULT_COUNT_VALUE, 32'h0);
        wr_reg(`OFS_THRESHOLD_COUNT_LIMIT, 32'h1ff);
        chk_reg("tcl_rw", `OFS_THRESHOLD_COUNT_LIMIT, 32'hff);
        chk_reg("unmapped", 32'hffff0600, 32'h0);
        // result counter wrap and interrupt thinning
        wr_reg(`OFS_ADC_CONFIGURATION, 32'h1);
        wr_reg(`OFS_IRQ_ENABLE, 32'h1);
        wr_reg(`OFS_RESULT_COUNT_LIMIT, 32'h3);
        conv(16'h1234);
        conv(16'h0042);
        chk_reg("rcv_two", `OFS_RESULT_COUNT_VALUE, 32'h2);
        check("irq_quiet", {31'h0, irq}, 32'h0);
        conv(16'h0007);
        chk_reg("rcv_wrap", `OFS_RESULT_COUNT_VALUE, 32'h0);
        check("irq_limit", {31'h0, irq}, 32'h1);
        wr_reg(`OFS_IRQ_CLEAR, 32'h1);
        conv(16'h0001);
        check("irq_clr", {31'h0, irq}, 32'h0);
        chk_reg("sta_clr", `OFS_ADC_STATUS_FLAGS, 32'h0);
        wr_reg(`OFS_ADC_CONFIGURATION, 32'h0);
        conv(16'h0001);
        chk_reg("rcv_off", `OFS_RESULT_COUNT_VALUE, 32'h1);
        chk_reg("sta_free", `OFS_ADC_STATUS_FLAGS, 32'h1);
        check("irq_free", {31'h0, irq}, 32'h1);
        wr_reg(`OFS_ADC_CONFIGURATION, 32'h1);
        wr_reg(`OFS_CURRENT_CHANNEL_CTRL, 32'h0);
        chk_reg("rcv_ctrl", `OFS_RESULT_COUNT_VALUE, 32'h0);
        conv(16'h0001);
        wr_reg(`OFS_ADC_MODE_REGISTER, 32'h5a5a);
        chk_reg("rcv_mode", `OFS_RESULT_COUNT_VALUE, 32'h0);
        chk_reg("mode_rw", `OFS_ADC_MODE_REGISTER, 32'h5a5a);
        // comparator with random threshold, coding and below action
        wr_reg(`OFS_IRQ_ENABLE, 32'h2);
        chk_reg("ien_rw", `OFS_IRQ_ENABLE, 32'h2);
        chk_reg("clr_wo", `OFS_IRQ_CLEAR, 32'h0);
        thv = 8'h0;
        for (int r = 0; r < 4; r++)
        begin
            th  = (r == 0) ? 16'h0 : 16'($urandom);
            tc  = (r < 2) ? r[0] : 1'($urandom);
            clr = (r < 2) ? !r[0] : 1'($urandom);
            tcl = 8'(1 + $urandom % 4);
            flag = 1'b0;
            wr_reg(`OFS_CURRENT_CHANNEL_CTRL, {31'h0, tc});
            wr_reg(`OFS_ADC_CONFIGURATION, {29'h0, clr, 2'b10});
            chk_reg("cfg_rw", `OFS_ADC_CONFIGURATION, {29'h0, clr, 2'b10});
            wr_reg(`OFS_CURRENT_THRESHOLD, {16'h0, th});
            wr_reg(`OFS_THRESHOLD_COUNT_LIMIT, {24'h0, tcl});
            wr_reg(`OFS_IRQ_CLEAR, 32'h2);
            for (int i = 0; i < 12; i++)
            begin
                v = (i == 0) ? 16'h8000 : (i == 1) ? th : (i == 2) ? th - 16'h1 : 16'($urandom);
                conv(v);
                if (is_above(v, th, tc))
                    thv = (thv == 8'hff) ? thv : thv + 8'h1;
                else
                    thv = clr ? 8'h0 : ((thv == 8'h0) ? thv : thv - 8'h1);
                if (thv == tcl)
                    flag = 1'b1;
                chk_reg("thv", `OFS_THRESHOLD_COUNT_VALUE, {24'h0, thv});
                rd_reg(`OFS_ADC_STATUS_FLAGS, d);
                check("thr_flag", {31'h0, d[1]}, {31'h0, flag});
            end
            check("thr_irq", {31'h0, irq}, {31'h0, flag});
        end
        wr_reg(`OFS_ADC_CONFIGURATION, 32'h0);
        conv(16'h7fff);
        chk_reg("thv_off", `OFS_THRESHOLD_COUNT_VALUE, {24'h0, thv});
        // second reset in mid-run restores the defaults
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg("thv_rst2", `OFS_THRESHOLD_COUNT_VALUE, 32'h0);
        chk_reg("tcl_rst2", `OFS_THRESHOLD_COUNT_LIMIT, 32'h1);
        chk_reg("rcl_rst2", `OFS_RESULT_COUNT_LIMIT, 32'h1);
        check("irq_rst2", {31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire
